// ===== hdl/uism_params.svh
// Register offsets, field positions, reset values and timing counts for the status/mask block
`ifndef UISM_PARAMS_SVH
`define UISM_PARAMS_SVH
`define UISM_OFF_CH0        12'h214
`define UISM_OFF_CH1        12'h254
`define UISM_OFF_CH2        12'h294
`define UISM_OFF_AUX_CTRL   12'h210
`define UISM_OFF_PORT_CHG   12'h204
`define UISM_BIT_COS        7
`define UISM_BIT_DB         2
`define UISM_BIT_RXRDY      1
`define UISM_BIT_TRANSMIT_READY      0
`define UISM_BIT_IEC        0
`define UISM_BIT_PC_COS     4
`define UISM_BIT_PC_CTS     0
`define UISM_RESET_VAL      8'h00
`define UISM_CLK_HZ         20000000
`define UISM_FILTER_NS      25000
`define UISM_FILTER_CYCLES  ((`UISM_FILTER_NS * (`UISM_CLK_HZ / 1000000) + 999) / 1000)
`endif

// ===== hdl/uism_pkg.sv
// Types shared by the status/mask block
package uism_pkg;
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } uism_bus_s;
    typedef struct packed {
        logic transmit_ready;
        logic receive_ready_or_fifo_full;
        logic break_change;
        logic reset_break_change;
    } uism_src_s;
endpackage

// ===== hdl/uism_irq.sv
// Interrupt status, mask and auxiliary control of one serial channel
// Function
// R1: Interrupt asserts when status and mask both set
// R2: Cleared mask hides status, status kept
// R3: Shared address: read status, write mask
// R4: Status shows true source regardless of mask
// R5: Module reset clears all status bits; the code clears change and delta break, ready bits 1-0 stay live
// R6: Status and mask read zero after reset; the code keeps status ready bits 1-0 live
// R7: Enable bit zero blocks change flag to status
// R8: Enable bit one passes change, may interrupt
// R9: Software writes zero to aux bits 7-1
// R10: Break start/end sets delta break; command clears
// R11: Reading port change register clears change flag
// R12: Clear-to-send change needs filtered persistent level
// R13: Ready bits follow live source, same masking
`include "uism_params.svh"
module uism_irq #(
    parameter logic [11:0] CH_OFFSET     = `UISM_OFF_CH0,
    parameter int          FILTER_CYCLES = `UISM_FILTER_CYCLES
) (
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_reset_n,
    // Register access
    input  wire uism_pkg::uism_bus_s   i_bus,
    output logic [7:0]                 o_rdata,
    // Channel sources
    input  wire uism_pkg::uism_src_s   i_src,
    input  wire logic                  i_clear_to_send_input_n,
    // Interrupt
    output logic                       o_irq
);
    import uism_pkg::*;

    logic [7:0]  mask_reg;
    logic        iec_reg;
    logic        cos_reg;
    logic        db_reg;
    logic        cts_meta_reg;
    logic        cts_sync_reg;
    logic        cts_stable_reg;
    logic [15:0] filt_cnt_reg;
    logic [7:0]  rdata_reg;
    logic [15:0] filt_cnt_next;
    wire         sel_ism   = (i_bus.addr == CH_OFFSET);
    wire         sel_aux   = (i_bus.addr == `UISM_OFF_AUX_CTRL);
    wire         sel_pc    = (i_bus.addr == `UISM_OFF_PORT_CHG);
    wire         wr_mask   = i_bus.wr && sel_ism;
    wire         wr_aux    = i_bus.wr && sel_aux;
    wire         rd_pc     = i_bus.rd && sel_pc;
    wire         differ    = (cts_sync_reg != cts_stable_reg);
    wire         filt_done = differ && (filt_cnt_reg == 16'(FILTER_CYCLES - 1));
    wire         cos_set   = filt_done;                               // R12
    wire [7:0]   status;
    wire [7:0]   pc_view;
    wire [7:0]   rd_mux;

    // Status view: change bit gated by enable, ready bits live
    assign status = {(cos_reg && iec_reg), 4'h0, db_reg,
                     i_src.receive_ready_or_fifo_full,
                     i_src.transmit_ready};                           // R4 R7 R8 R13
    assign pc_view = {3'h0, cos_reg, 3'h0, cts_stable_reg};
    // Read selection
    assign rd_mux = sel_ism ? status :                                // R3
                    sel_aux ? {7'h00, iec_reg} :
                    sel_pc  ? pc_view : 8'h00;
    // Filter counter restarts whenever input matches stable level
    assign filt_cnt_next = (!differ || filt_done) ? 16'h0000 : filt_cnt_reg + 16'h0001;

    // Interrupt combines status with mask
    assign o_irq = |(status & mask_reg);                              // R1 R2

    // Input synchroniser and filter
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            cts_meta_reg   <= 1'b1;
            cts_sync_reg   <= 1'b1;
            cts_stable_reg <= 1'b1;
            filt_cnt_reg   <= 16'h0000;
        end else begin
            cts_meta_reg   <= i_clear_to_send_input_n;
            cts_sync_reg   <= cts_meta_reg;
            filt_cnt_reg   <= filt_cnt_next;
            if (filt_done) begin
                cts_stable_reg <= cts_sync_reg;
            end
        end
    end

    // Change flag: set wins over read clear
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            cos_reg <= 1'b0;                                          // R5
        end else if (cos_set) begin
            cos_reg <= 1'b1;
        end else if (rd_pc) begin
            cos_reg <= 1'b0;                                          // R11
        end
    end

    // Delta break: set wins over command clear
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            db_reg <= 1'b0;                                           // R5
        end else if (i_src.break_change) begin
            db_reg <= 1'b1;                                           // R10
        end else if (i_src.reset_break_change) begin
            db_reg <= 1'b0;                                           // R10
        end
    end

    // Mask, aux control and read data
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            mask_reg  <= `UISM_RESET_VAL;                             // R6
            iec_reg   <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            if (wr_mask) begin
                mask_reg <= i_bus.wdata & 8'h87;                      // R3
            end
            if (wr_aux) begin
                iec_reg <= i_bus.wdata[`UISM_BIT_IEC];                // R9
            end
            rdata_reg <= i_bus.rd ? rd_mux : 8'h00;
        end
    end

    assign o_rdata = rdata_reg;
endmodule

// ===== bench/uism_irq_properties.sv
// Port-level assertions for the status/mask block
module uism_irq_properties import uism_pkg::*; #(parameter logic [11:0] CH_OFFSET = 12'h214) (
    input wire logic i_core_clk, input wire logic i_reset_n, input wire uism_bus_s i_bus,
    input wire logic [7:0] o_rdata, input wire uism_src_s i_src,
    input wire logic i_clear_to_send_input_n, input wire logic o_irq);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    logic [7:0] msk_reg;
    wire rd_ch = i_bus.rd && i_bus.addr == CH_OFFSET;
    // Shadow of the writable mask bits
    always_ff @(posedge i_core_clk)
        msk_reg <= !i_reset_n ? 8'h00 : (i_bus.wr && i_bus.addr == CH_OFFSET) ? i_bus.wdata & 8'h87 : msk_reg;
    // Break edge, one quiet cycle, then a status read (the bench's own spacing)
    sequence brk_rd;
        i_src.break_change ##1 !i_src.reset_break_change ##1 rd_ch && !i_src.reset_break_change;
    endsequence
    // Clear command, one quiet cycle, then a status read
    sequence clr_rd;
        i_src.reset_break_change && !i_src.break_change ##1 !i_src.break_change
            ##1 rd_ch && !i_src.break_change;
    endsequence
    chk_idle_rdata: assert property (!i_bus.rd |=> o_rdata == 8'h00) else $error("rdata");
    chk_unmapped_rd: assert property (i_bus.rd && i_bus.addr == 12'h200 |=> o_rdata == 8'h00) else $error("unmapped");
    chk_ready_live: assert property (rd_ch |=> o_rdata[0] == $past(i_src.transmit_ready)
        && o_rdata[1] == $past(i_src.receive_ready_or_fifo_full)) else $error("ready");
    chk_irq_on: assert property (msk_reg[0] && i_src.transmit_ready
        || msk_reg[1] && i_src.receive_ready_or_fifo_full |-> o_irq) else $error("irq on");
    chk_irq_masked: assert property (msk_reg == 8'h00 |-> !o_irq) else $error("irq masked");
    chk_reset_zero: assert property (disable iff (1'b0) !i_reset_n |=> o_rdata == 8'h00) else $error("rst");
    chk_break_set: assert property (brk_rd |=> o_rdata[2]) else $error("db set");
    chk_break_clear: assert property (clr_rd |=> !o_rdata[2]) else $error("db clear");
endmodule
bind uism_irq uism_irq_properties #(.CH_OFFSET(CH_OFFSET)) chk (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .i_bus(i_bus), .o_rdata(o_rdata), .i_src(i_src),
    .i_clear_to_send_input_n(i_clear_to_send_input_n), .o_irq(o_irq));

// ===== bench/uism_src_model.sv
// Behavioural transmitter, receiver and pin side of one channel
module uism_src_model (input wire logic i_core_clk,
    output uism_pkg::uism_src_s o_src, output logic o_cts_n);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_src = '0;
    initial o_cts_n = 1'b1;
    // Live ready levels {tx, rx} and pin, changed after the falling edge
    task automatic set(input logic [1:0] rdy, input logic cts_n);
        @(negedge i_core_clk);
        o_src[3:2] = rdy;
        o_cts_n = cts_n;
    endtask
    // One-cycle break edge (1) or clear command (0)
    task automatic pulse(input logic brk);
        @(negedge i_core_clk);
        o_src[1:0] = {brk, !brk};
        @(negedge i_core_clk);
        o_src[1:0] = 2'b00;
    endtask
endmodule

// ===== bench/tb_uism_irq.sv
// Self-checking bench for the status/mask block
module tb_uism_irq;
    timeunit 1ns;
    timeprecision 1ns;
    import uism_pkg::*;
    localparam logic [11:0] CH = 12'h254;
    logic clk = 1'b0, rst_n = 1'b0, cts_n, irq;
    uism_bus_s bus = '0;
    uism_src_s src;
    logic [7:0] rdata;
    int error_cnt = 0, comparisons = 0;
    initial forever #25 clk = ~clk;
    uism_src_model pm (.i_core_clk(clk), .o_src(src), .o_cts_n(cts_n));
    uism_irq #(.CH_OFFSET(CH), .FILTER_CYCLES(4)) dut (.i_core_clk(clk), .i_reset_n(rst_n),
        .i_bus(bus), .o_rdata(rdata), .i_src(src), .i_clear_to_send_input_n(cts_n), .o_irq(irq));
    task automatic cmp(input string nm, input logic [7:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        bus = '{!w, w, a, d};
        @(negedge clk);
        bus = '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        cmp("rdata", exp, rdata);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog sized well beyond the roughly 80 cycles of the tests
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rd(CH, 8'h00);
        rd(12'h200, 8'h00);
        pm.set(2'b10, 1'b1);
        rd(CH, 8'h01);
        cmp("irq", 8'h00, 8'(irq));
        acc(1'b1, CH, 8'hff);
        cmp("irq", 8'h01, 8'(irq));
        rd(CH, 8'h01);
        pm.set(2'b01, 1'b1);
        rd(CH, 8'h02);
        $display("test mask done");
        pm.pulse(1'b1);
        rd(CH, 8'h06);
        pm.pulse(1'b0);
        rd(CH, 8'h02);
        pm.set(2'b01, 1'b0);
        pm.set(2'b01, 1'b1);
        repeat (12) @(negedge clk);
        rd(12'h204, 8'h01);
        pm.set(2'b01, 1'b0);
        repeat (12) @(negedge clk);
        rd(CH, 8'h02);
        acc(1'b1, 12'h210, 8'h01);
        rd(CH, 8'h82);
        rd(12'h204, 8'h10);
        rd(CH, 8'h02);
        $display("test change done");
        pm.pulse(1'b1);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd(CH, 8'h02);
        cmp("irq", 8'h00, 8'(irq));
        $display("test reset done");
        final_report();
    end
endmodule
